// file: logic/cmd_reg_pkg.sv
// Constants for the two-function configuration command register block
package cmd_reg_pkg;
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam int CMD_WIDTH = 16;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    // Bits that software can change; all others read zero
    localparam logic [15:0] CMD_WRITE_MASK = 16'h0567;
    localparam int BIT_IO_SPACE = 0;
    localparam int BIT_MEM_SPACE = 1;
    localparam int BIT_INITIATOR = 2;
    localparam int BIT_SPECIAL = 3;
    localparam int BIT_WRITE_INVALIDATE = 4;
    localparam int BIT_PALETTE_SNOOP = 5;
    localparam int BIT_PARITY_RESPONSE = 6;
    localparam int BIT_SYSTEM_ERROR = 8;
    localparam int BIT_BACK_TO_BACK = 9;
    localparam int BIT_INT_BLOCK = 10;
    localparam int NUM_FUNCS = 2;
endpackage

// file: logic/cmd_word.sv
// One function's command register word with its hardwired bits
`timescale 1ns/100ps
module cmd_word
    import cmd_reg_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_be_i,
    input wire logic [15:0] wr_data_i,
    output logic [15:0] value_o
);
    import cmd_reg_pkg::*;

    logic [15:0] cmd_reg;
    logic [15:0] cmd_next;
    logic [15:0] lane_mask;

    // Only writable bits in enabled byte lanes take new data
    assign lane_mask = {{8{wr_be_i[1]}}, {8{wr_be_i[0]}}} & CMD_WRITE_MASK;
    assign cmd_next = (cmd_reg & ~lane_mask) | (wr_data_i & lane_mask); // R19

    // Register holds; reserved and hardwired bits never store
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_reg <= CMD_RESET;
        end else if (wr_en_i) begin
            cmd_reg <= cmd_next;
        end
    end

    assign value_o = cmd_reg & CMD_WRITE_MASK; // R1 R3 R6 R10 R11

    a_fixed_zero: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
        (value_o & ~CMD_WRITE_MASK) == 16'h0000)
        else $error("hardwired command bit reads nonzero");
    a_ro_write_drop: assert property ( // R19
        @(posedge mclk_i) disable iff (rst_i)
        (wr_en_i && wr_be_i == 2'b00) |=> $stable(value_o))
        else $error("write with no lanes changed register");
endmodule

// file: logic/cmd_reg_top.sv
// Command registers of two functions and the bus gating they steer
//
// Notes on behaviour
// (R1) Bits 15 to 11 always read zero.
// (R2) Interrupt-block bit 10 set stops the function driving INTx.
// (R3) Back-to-back enable bit 9 is read-only zero.
// (R4) Bit 8 enables the system error output driver.
// (R5) Address parity errors reported only with bits 8 and 6 both set.
// (R6) Reserved bit 7 always reads zero.
// (R7) Bit 6 clear makes detected parity errors ignored.
// (R8) With parity response on, data parity errors raise system error.
// (R9) Palette snoop bit 5: do not claim palette writes, capture data.
// (R10) Bit 4 zero; initiator uses plain memory writes only.
// (R11) Bit 3 zero; special cycles are never answered.
// (R12) Initiator requests allowed only while bit 2 is set.
// (R13) Memory cycles claimed only while bit 1 is set.
// (R14) I/O cycles claimed only while bit 0 is set.
// (R15) Each function has its own independent command register.
// (R16) Shared error logic uses OR of both functions' bits 8 and 6.
// (R17) INTx asserts only when pending and not blocked; pending unaffected.
// (R18) Master data parity flag needs PERR, mastership and bit 6.
// (R19) Writes to read-only and reserved bits change nothing.
`timescale 1ns/100ps
module cmd_reg_top
    import cmd_reg_pkg::*;
#(
    parameter int FUNCS = 2
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    // Configuration access, one function selected
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_func_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    // Per-function decode and request inputs
    input wire logic [1:0] mem_hit_i,
    input wire logic [1:0] io_hit_i,
    input wire logic [1:0] palette_write_i,
    input wire logic [1:0] special_cycle_i,
    input wire logic [1:0] init_req_i,
    input wire logic [1:0] init_write_i,
    input wire logic [1:0] int_pending_i,
    input wire logic [15:0] bus_data_i,
    // Shared error events
    input wire logic addr_parity_err_i,
    input wire logic data_parity_err_i,
    input wire logic perr_seen_i,
    input wire logic [1:0] master_phase_i,
    // Outputs
    output logic [1:0] claim_o,
    output logic [1:0] init_grant_req_o,
    output logic [1:0] write_invalidate_o,
    output logic [1:0] int_o,
    output logic [15:0] palette_data_o,
    output logic serr_o,
    output logic serr_oe_o,
    output logic perr_respond_o,
    output logic [1:0] master_data_parity_flag_o
);
    import cmd_reg_pkg::*;

    logic [15:0] cmd_val [2];
    logic cmd_hit;
    logic [1:0] func_wr;
    logic [1:0] serr_bits;
    logic [1:0] perr_bits;
    logic serr_any;
    logic perr_any;
    logic serr_event;
    logic [15:0] rdata_next;
    logic [15:0] rdata_reg;
    logic [15:0] palette_reg;
    logic serr_reg;
    logic [1:0] flag_reg;
    logic [1:0] snoop_take;

    // Address decode for the command word
    assign cmd_hit = (cfg_addr_i == CMD_OFFSET);

    // One independent word per function
    genvar f;
    generate
        for (f = 0; f < FUNCS; f++) begin : g_func
            assign func_wr[f] = cfg_wr_i && cmd_hit && (cfg_func_i == 1'(f));
            cmd_word u_word (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .wr_en_i(func_wr[f]),
                .wr_be_i(cfg_be_i),
                .wr_data_i(cfg_wdata_i),
                .value_o(cmd_val[f])
            ); // R15
            assign serr_bits[f] = cmd_val[f][BIT_SYSTEM_ERROR];
            assign perr_bits[f] = cmd_val[f][BIT_PARITY_RESPONSE];
            // Decoded cycles are claimed only when the space is enabled
            assign claim_o[f] =
                (mem_hit_i[f] && cmd_val[f][BIT_MEM_SPACE] // R13
                 && !(palette_write_i[f]
                      && cmd_val[f][BIT_PALETTE_SNOOP])) // R9
                || (io_hit_i[f] && cmd_val[f][BIT_IO_SPACE]); // R14
            assign snoop_take[f] = palette_write_i[f]
                && cmd_val[f][BIT_PALETTE_SNOOP]; // R9
            assign init_grant_req_o[f] = init_req_i[f]
                && cmd_val[f][BIT_INITIATOR]; // R12
            // No invalidate form ever issued; special cycles ignored
            assign write_invalidate_o[f] = 1'b0; // R10 R11
            assign int_o[f] = int_pending_i[f]
                && !cmd_val[f][BIT_INT_BLOCK]; // R2 R17
        end
    endgenerate

    // Shared error logic sees either function's enables
    assign serr_any = |serr_bits; // R16
    assign perr_any = |perr_bits; // R16
    assign perr_respond_o = perr_any; // R7
    assign serr_event = serr_any && perr_any && addr_parity_err_i // R5
        || perr_any && data_parity_err_i; // R8
    assign serr_oe_o = serr_any && serr_reg; // R4
    assign serr_o = 1'b0; // Open drain: pin driven low when enabled

    // Read data returns the masked word, other offsets read zero
    assign rdata_next = cmd_hit ? cmd_val[cfg_func_i] : 16'h0000;
    assign cfg_rdata_o = rdata_reg;

    // Captured read data and snooped palette data
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 16'h0000;
            palette_reg <= 16'h0000;
        end else begin
            if (cfg_rd_i) begin
                rdata_reg <= rdata_next;
            end
            if (|snoop_take) begin
                palette_reg <= bus_data_i; // R9
            end
        end
    end
    assign palette_data_o = palette_reg;

    // System error pulse registered for the driver
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            serr_reg <= 1'b0;
        end else begin
            serr_reg <= serr_event && serr_any; // R4
        end
    end

    // Sticky flag: set wins; clearing belongs to the status block
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_reg <= 2'b00;
        end else begin
            flag_reg <= flag_reg | ({2{perr_seen_i}} & master_phase_i
                & perr_bits); // R18
        end
    end
    assign master_data_parity_flag_o = flag_reg;

    // Every check below runs on the bus clock and sleeps through reset
    default clocking cb_main @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Steps of an error report: an enabled event, then a quiet cycle
    sequence s_addr_err_armed;
        addr_parity_err_i && serr_any && perr_any;
    endsequence
    sequence s_data_err_armed;
        data_parity_err_i && perr_any && serr_any;
    endsequence
    sequence s_quiet;
        !addr_parity_err_i && !data_parity_err_i;
    endsequence

    a_int_block: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
        cmd_val[0][BIT_INT_BLOCK] |-> !int_o[0])
        else $error("interrupt driven while blocked");
    a_int_pending: assert property ( // R17
        @(posedge mclk_i) disable iff (rst_i)
        (int_pending_i[1] && !cmd_val[1][BIT_INT_BLOCK]) |-> int_o[1])
        else $error("pending interrupt not driven");
    a_serr_gate: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
        serr_oe_o |-> serr_any && $past(serr_event))
        else $error("system error driven without enable");
    a_addr_parity: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
        (addr_parity_err_i && serr_any && perr_any) |=> serr_oe_o)
        else $error("address parity error not reported");
    a_data_parity: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
        (data_parity_err_i && perr_any && serr_any) |=> serr_oe_o)
        else $error("data parity error not signalled");
    a_perr_ignore: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
        !perr_any |=> !serr_oe_o)
        else $error("parity reaction while disabled");
    a_initiator_gate: assert property ( // R12
        @(posedge mclk_i) disable iff (rst_i)
        init_grant_req_o[0] |-> cmd_val[0][BIT_INITIATOR] && init_req_i[0])
        else $error("initiator request while disabled");
    a_mem_claim: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
        (mem_hit_i[0] && !io_hit_i[0] && !cmd_val[0][BIT_MEM_SPACE])
        |-> !claim_o[0])
        else $error("memory cycle claimed while disabled");
    a_io_claim: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
        (io_hit_i[1] && !mem_hit_i[1] && !cmd_val[1][BIT_IO_SPACE])
        |-> !claim_o[1])
        else $error("io cycle claimed while disabled");
    a_snoop_claim: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
        snoop_take[0] |-> !claim_o[0] || io_hit_i[0])
        else $error("snooped palette write was claimed");
    a_no_invalidate: assert property ( // R10
        @(posedge mclk_i) disable iff (rst_i)
        write_invalidate_o == 2'b00)
        else $error("write and invalidate issued");
    a_separate_regs: assert property ( // R15
        @(posedge mclk_i) disable iff (rst_i)
        (cfg_wr_i && cmd_hit && !cfg_func_i) |=> $stable(cmd_val[1]))
        else $error("write to one function changed the other");
    a_flag_cause: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
        (!$past(flag_reg[0]) && flag_reg[0]) |->
        $past(perr_seen_i && master_phase_i[0] && perr_bits[0]))
        else $error("parity flag set without cause");

    // Interrupt gating on the other function of each pair
    a_int_block_f1: assert property ( // R2
        cmd_val[1][BIT_INT_BLOCK] |-> !int_o[1])
        else $error("interrupt driven while blocked");
    a_int_pending_f0: assert property ( // R17
        (int_pending_i[0] && !cmd_val[0][BIT_INT_BLOCK]) |-> int_o[0])
        else $error("pending interrupt not driven");
    a_int_source: assert property ( // R17
        int_o[1] |-> int_pending_i[1])
        else $error("interrupt driven with nothing pending");

    // Space claims and initiator requests on the other function
    a_init_gate_f1: assert property ( // R12
        init_grant_req_o[1] |-> cmd_val[1][BIT_INITIATOR])
        else $error("initiator request while disabled");
    a_mem_claim_f1: assert property ( // R13
        (mem_hit_i[1] && !io_hit_i[1] && !cmd_val[1][BIT_MEM_SPACE])
        |-> !claim_o[1])
        else $error("memory cycle claimed while disabled");
    a_io_claim_f0: assert property ( // R14
        (io_hit_i[0] && !mem_hit_i[0] && !cmd_val[0][BIT_IO_SPACE])
        |-> !claim_o[0])
        else $error("io cycle claimed while disabled");
    a_special_ignored: assert property ( // R11
        (special_cycle_i & ~mem_hit_i & ~io_hit_i & claim_o) == 2'b00)
        else $error("special cycle was claimed");
    a_invalidate_write: assert property ( // R10
        ((init_grant_req_o & init_write_i) != 2'b00)
        |-> write_invalidate_o == 2'b00)
        else $error("initiator write used the invalidate form");

    // Palette snoop: no claim, data captured on the next edge
    a_snoop_f1: assert property ( // R9
        snoop_take[1] |-> !claim_o[1] || io_hit_i[1])
        else $error("snooped palette write was claimed");
    a_palette_capture: assert property ( // R9
        (|snoop_take) |=> palette_data_o == $past(bus_data_i))
        else $error("snooped palette data not captured");

    // Register words and read data
    a_separate_f0: assert property ( // R15
        (cfg_wr_i && cmd_hit && cfg_func_i) |=> $stable(cmd_val[0]))
        else $error("write to one function changed the other");
    a_rdata_cmd: assert property ( // R1
        (cfg_rd_i && cmd_hit) |=> cfg_rdata_o == $past(cmd_val[cfg_func_i]))
        else $error("command read returned the wrong word");
    a_rdata_reserved: assert property ( // R3 R6
        (cfg_rdata_o & ~CMD_WRITE_MASK) == 16'h0000)
        else $error("read data shows a fixed-zero bit set");
    a_rdata_other: assert property ( // R1
        (cfg_rd_i && !cmd_hit) |=> cfg_rdata_o == 16'h0000)
        else $error("read outside the command word not zero");

    // Parity flag of the second function
    a_flag_cause_f1: assert property ( // R18
        (!$past(flag_reg[1]) && flag_reg[1]) |->
        $past(perr_seen_i && master_phase_i[1] && perr_bits[1]))
        else $error("parity flag set without cause");
    a_flag_sticky: assert property ( // R18
        flag_reg[1] |=> flag_reg[1])
        else $error("parity flag dropped without reset");

    // System error driver: enabled, shared and one cycle per event
    a_serr_no_enable: assert property ( // R4
        !serr_any |-> !serr_oe_o)
        else $error("system error driven without enable");
    a_addr_one_cycle: assert property ( // R5
        s_addr_err_armed ##1 s_quiet |=> !serr_oe_o)
        else $error("address error report outlasted its event");
    a_data_one_cycle: assert property ( // R8
        s_data_err_armed ##1 s_quiet |=> !serr_oe_o)
        else $error("data error report outlasted its event");
    a_shared_serr: assert property ( // R16
        (serr_bits[0] && perr_bits[1] && addr_parity_err_i && !cfg_wr_i)
        |=> serr_oe_o)
        else $error("enables of both functions not merged");
endmodule

// file: tb/bus_agent_model.sv
// Bus agent model that raises one-cycle parity error events
`timescale 1ns/100ps
module bus_agent_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [2:0] kind_i,
    output logic addr_parity_err_o,
    output logic data_parity_err_o,
    output logic perr_seen_o
);
    // Events last one cycle, since a real agent flags each phase once
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {addr_parity_err_o, data_parity_err_o, perr_seen_o} <= 3'h0;
        end else begin
            {addr_parity_err_o, data_parity_err_o, perr_seen_o} <=
                fire_i ? kind_i : 3'h0;
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking bench for the two-function command register block
`timescale 1ns/100ps
module tb;
    import cmd_reg_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, fire = 1'b0;
    logic cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, cfg_func_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00;
    logic [2:0] kind = 3'h0;
    logic [1:0] cfg_be_i = 2'h0, mem_hit_i = 2'h3, io_hit_i = 2'h3;
    logic [1:0] palette_write_i = 2'h0, special_cycle_i = 2'h3;
    logic [1:0] init_req_i = 2'h3, init_write_i = 2'h3;
    logic [1:0] int_pending_i = 2'h3, master_phase_i = 2'h0;
    logic [15:0] cfg_wdata_i = 16'h0000, bus_data_i = 16'h0000;
    logic [15:0] cfg_rdata_o, palette_data_o;
    logic [1:0] claim_o, init_grant_req_o, write_invalidate_o, int_o;
    logic [1:0] master_data_parity_flag_o;
    logic serr_o, serr_oe_o, perr_respond_o;
    logic addr_parity_err_i, data_parity_err_i, perr_seen_i;
    int mismatches = 0, comparisons = 0;

    cmd_reg_top u_cmd_reg_top (.mclk_i(mclk_i), .rst_i(rst_i),
        .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_func_i(cfg_func_i),
        .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .mem_hit_i(mem_hit_i), .io_hit_i(io_hit_i),
        .palette_write_i(palette_write_i), .special_cycle_i(special_cycle_i),
        .init_req_i(init_req_i), .init_write_i(init_write_i),
        .int_pending_i(int_pending_i), .bus_data_i(bus_data_i),
        .addr_parity_err_i(addr_parity_err_i),
        .data_parity_err_i(data_parity_err_i), .perr_seen_i(perr_seen_i),
        .master_phase_i(master_phase_i), .claim_o(claim_o),
        .init_grant_req_o(init_grant_req_o),
        .write_invalidate_o(write_invalidate_o), .int_o(int_o),
        .palette_data_o(palette_data_o), .serr_o(serr_o),
        .serr_oe_o(serr_oe_o), .perr_respond_o(perr_respond_o),
        .master_data_parity_flag_o(master_data_parity_flag_o));
    bus_agent_model u_bus_agent_model (.mclk_i(mclk_i), .rst_i(rst_i),
        .fire_i(fire), .kind_i(kind), .addr_parity_err_o(addr_parity_err_i),
        .data_parity_err_o(data_parity_err_i), .perr_seen_o(perr_seen_i));

    // 200 MHz clock
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Compare one value and count the result
    task automatic check(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Configuration write to the command offset, strobe held one edge
    task automatic wr(input logic f, input logic [1:0] be,
                      input logic [15:0] d);
        @(posedge mclk_i);
        cfg_wr_i <= 1'b1;
        cfg_func_i <= f;
        cfg_addr_i <= CMD_OFFSET;
        cfg_be_i <= be;
        cfg_wdata_i <= d;
        @(posedge mclk_i);
        cfg_wr_i <= 1'b0;
    endtask

    // Read one offset; data is settled just after the taking edge
    task automatic rd(input logic f, input logic [7:0] a,
                      input logic [15:0] exp);
        @(posedge mclk_i);
        cfg_rd_i <= 1'b1;
        cfg_func_i <= f;
        cfg_addr_i <= a;
        @(posedge mclk_i);
        cfg_rd_i <= 1'b0;
        #1;
        check("read data", cfg_rdata_o, exp);
    endtask

    // Fire one agent event and stop just after the design registers it
    task automatic ev(input logic [2:0] k);
        @(posedge mclk_i);
        fire <= 1'b1;
        kind <= k;
        @(posedge mclk_i);
        fire <= 1'b0;
        @(posedge mclk_i);
        #1;
    endtask

    // Reset state: words zero, all gates shut except interrupts
    task automatic t_reset;
        rd(1'b0, CMD_OFFSET, 16'h0000);
        rd(1'b1, CMD_OFFSET, 16'h0000);
        check("claim", {14'h0, claim_o}, 16'h0000);
        check("grant", {14'h0, init_grant_req_o}, 16'h0000);
        check("int", {14'h0, int_o}, 16'h0003);
        $display("reset test done");
    endtask

    // Read-only bits drop writes; functions stay apart; lanes honoured
    task automatic t_mask;
        wr(1'b0, 2'h3, 16'hFFFF);
        rd(1'b0, CMD_OFFSET, 16'h0567);
        rd(1'b1, CMD_OFFSET, 16'h0000);
        wr(1'b1, 2'h1, 16'hFFFF);
        rd(1'b1, CMD_OFFSET, 16'h0067);
        rd(1'b0, 8'h06, 16'h0000);
        check("claim", {14'h0, claim_o}, 16'h0003);
        check("grant", {14'h0, init_grant_req_o}, 16'h0003);
        check("int", {14'h0, int_o}, 16'h0002);
        check("mwi", {14'h0, write_invalidate_o}, 16'h0000);
        $display("mask test done");
    endtask

    // Palette snoop hides the memory claim and captures the data
    task automatic t_snoop;
        @(posedge mclk_i);
        io_hit_i <= 2'h0;
        palette_write_i <= 2'h3;
        bus_data_i <= 16'hA5C3;
        @(posedge mclk_i);
        #1;
        check("snoop claim", {14'h0, claim_o}, 16'h0000);
        @(posedge mclk_i);
        #1;
        check("palette", palette_data_o, 16'hA5C3);
        wr(1'b0, 2'h3, 16'h0002);
        wr(1'b1, 2'h3, 16'h0000);
        #1;
        check("claim", {14'h0, claim_o}, 16'h0001);
        check("grant", {14'h0, init_grant_req_o}, 16'h0000);
        check("int", {14'h0, int_o}, 16'h0003);
        $display("snoop test done");
    endtask

    // Error enables merge across functions and gate the driver
    task automatic t_err;
        wr(1'b0, 2'h3, 16'h0100);
        wr(1'b1, 2'h3, 16'h0040);
        master_phase_i <= 2'h2;
        ev(3'h4);
        check("serr oe", {15'h0, serr_oe_o}, 16'h0001);
        check("perr resp", {15'h0, perr_respond_o}, 16'h0001);
        @(posedge mclk_i);
        #1;
        check("serr oe end", {15'h0, serr_oe_o}, 16'h0000);
        ev(3'h2);
        check("serr data", {15'h0, serr_oe_o}, 16'h0001);
        ev(3'h1);
        check("flag", {14'h0, master_data_parity_flag_o}, 16'h0002);
        wr(1'b1, 2'h3, 16'h0000);
        ev(3'h4);
        check("serr no perr", {15'h0, serr_oe_o}, 16'h0000);
        ev(3'h2);
        check("serr ignored", {15'h0, serr_oe_o}, 16'h0000);
        check("serr pin", {15'h0, serr_o}, 16'h0000);
        check("perr off", {15'h0, perr_respond_o}, 16'h0000);
        $display("error test done");
    endtask

    // Special cycles never claimed; I/O claimed only when enabled
    task automatic t_special;
        @(posedge mclk_i);
        mem_hit_i <= 2'h0;
        io_hit_i <= 2'h3;
        @(posedge mclk_i);
        #1;
        check("io off claim", {14'h0, claim_o}, 16'h0000);
        wr(1'b1, 2'h3, 16'h0003);
        #1;
        check("io on claim", {14'h0, claim_o}, 16'h0002);
        @(posedge mclk_i);
        io_hit_i <= 2'h0;
        @(posedge mclk_i);
        #1;
        check("special claim", {14'h0, claim_o}, 16'h0000);
        check("mwi", {14'h0, write_invalidate_o}, 16'h0000);
        $display("special test done");
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset;
        t_mask;
        t_snoop;
        t_err;
        t_special;
        close_out;
    end

    // Watchdog well beyond the roughly 60 cycles the tests need
    initial begin
        repeat (3000) @(posedge mclk_i);
        mismatches++;
        close_out;
    end
endmodule
